// *** logic/fbsc_defines.vh ***
// Constants for the flow-through burst SRAM control block
// Function
// - Clock-enable high freezes the control state on that edge; queued writes still drain to the core.
// - All selects active, enable low, load low: capture address, begin access.
// - Latch 17-bit address at access start; it addresses the core.
// - Write-select high at start means read; data flows out same cycle.
// - Read data drives lines only while output enable low, gated internally too.
// - A new operation may follow a read start on the very next edge.
// - Any select inactive on a load edge three-states outputs at once.
// - Burst counter gives up to four accesses from one loaded address.
// - Burst-order strap low means linear order, high means interleaved.
// - Counter touches only the two low address bits and wraps.
// - Advance high increments counter during a read or write burst, ignoring selects and write-select.
// - Direction is latched at load and kept for the whole burst.
// - Selects active, enable low, write-select low: capture address, start write.
// - During a write the data and parity lines are three-stated.
// - Write data taken on the next edge; new operation accepted there.
// - Only byte lanes with active lane select are written.
// - Selected only when sel_n_a low, sel_b high, sel_n_c low.
// - Four lanes of eight data bits plus one parity bit each.
// - Linear adds beat modulo four; interleaved XORs beat with start.
// - After reset the device is deselected with lines three-stated.
`ifndef FBSC_DEFINES_VH
`define FBSC_DEFINES_VH
`define FBSC_ADDR_W   17
`define FBSC_DATA_W   32
`define FBSC_PAR_W    4
`define FBSC_LANES    4
`define FBSC_WORD_W   36
`define FBSC_DEPTH    131072
`define FBSC_FIFO_D   32
`define FBSC_FIFO_AW  5
`define FBSC_BEAT_MAX 2'h3
`endif

// *** logic/fbsc_fifo.v ***
// Parameterised valid/ready FIFO used on the write data path
`timescale 1ns/1ps
module fbsc_fifo #(
  parameter WIDTH = 36,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;

  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// *** logic/fbsc_core.v ***
// Memory core with per-lane write enables and asynchronous read
`timescale 1ns/1ps
`include "fbsc_defines.vh"
module fbsc_core (
  input  wire                      clk,
  input  wire                      wr_en,
  input  wire [`FBSC_ADDR_W-1:0]   wr_addr,
  input  wire [`FBSC_LANES-1:0]    wr_lane,
  input  wire [`FBSC_WORD_W-1:0]   wr_word,
  input  wire [`FBSC_ADDR_W-1:0]   rd_addr,
  output wire [`FBSC_WORD_W-1:0]   rd_word
);
  genvar g;
  generate
    for (g = 0; g < `FBSC_LANES; g = g + 1) begin : lane
      reg  [8:0] mem [0:`FBSC_DEPTH-1];
      // Lane g holds data bits 8g..8g+7 and parity bit g
      always @(posedge clk) begin
        if (wr_en && wr_lane[g]) begin
          mem[wr_addr] <= wr_word[9*g +: 9];
        end
      end
      assign rd_word[9*g +: 9] = mem[rd_addr];
    end
  endgenerate
endmodule

// *** logic/fbsc_top.v ***
// Control logic of the flow-through burst SRAM
`timescale 1ns/1ps
`include "fbsc_defines.vh"
module fbsc_top (
  input  wire                    CLK_SYS,
  input  wire                    RESETN,
  input  wire                    CLK_QUALIFY_N,
  input  wire                    SEL_N_A,
  input  wire                    SEL_B,
  input  wire                    SEL_N_C,
  input  wire                    ADVANCE_OR_LOAD,
  input  wire                    WR_SELECT_N,
  input  wire [3:0]              LANE_WRITE_SEL_N,
  input  wire [`FBSC_ADDR_W-1:0] ADDR_IN,
  input  wire                    OUT_DRIVE_N,
  input  wire                    BURST_ORDER,
  input  wire [31:0]             DATA_LINES_I,
  output wire [31:0]             DATA_LINES_O,
  output wire [31:0]             DATA_LINES_OE,
  input  wire [3:0]              PARITY_LINES_I,
  output wire [3:0]              PARITY_LINES_O,
  output wire [3:0]              PARITY_LINES_OE,
  output wire                    WR_STALL
);
  localparam ST_IDLE  = 3'b001;
  localparam ST_READ  = 3'b010;
  localparam ST_WRITE = 3'b100;

  reg  [2:0]              st_q;
  reg  [2:0]              st_d;
  reg  [`FBSC_ADDR_W-1:0] base_q;
  reg  [1:0]              beat_q;
  reg                     order_q;
  reg  [`FBSC_ADDR_W-1:0] rd_data_addr_q;
  reg                     drive_q;
  wire                    qual;
  wire                    sel;
  wire                    load;
  wire                    adv;
  wire                    burst_ok;
  wire [1:0]              beat_n;
  wire [`FBSC_ADDR_W-1:0] cur_addr;
  wire [`FBSC_ADDR_W-1:0] nxt_addr;
  wire [`FBSC_WORD_W-1:0] core_rd;
  wire                    wr_issue;
  wire                    fifo_out_valid;
  wire [`FBSC_WORD_W-1:0] fifo_out_word;
  wire [`FBSC_WORD_W+`FBSC_ADDR_W+3:0] fifo_out_data;
  wire                    fifo_in_ready;

  // Burst address: linear adds, interleaved XORs the beat into the start bits
  function [1:0] fbsc_burst;
    input [1:0] start;
    input [1:0] beat;
    input       inter;
    begin
      if (inter) begin
        fbsc_burst = start ^ beat;
      end else begin
        fbsc_burst = start + beat;
      end
    end
  endfunction

  assign qual     = !CLK_QUALIFY_N;
  assign sel      = !SEL_N_A && SEL_B && !SEL_N_C;
  assign load     = qual && !ADVANCE_OR_LOAD;
  assign adv      = qual && ADVANCE_OR_LOAD;
  assign beat_n   = beat_q + 2'h1;
  assign burst_ok = (st_q != ST_IDLE);
  // Only the low two bits walk; upper bits stay from the load
  assign cur_addr = {base_q[`FBSC_ADDR_W-1:2], fbsc_burst(base_q[1:0], beat_q, order_q)};
  assign nxt_addr = {base_q[`FBSC_ADDR_W-1:2], fbsc_burst(base_q[1:0], beat_n, order_q)};

  // A write beat is queued on the edge after its address was taken; the core is written one edge later
  assign wr_issue = qual && (st_q == ST_WRITE);
  assign WR_STALL = !fifo_in_ready;

  always @* begin
    st_d = st_q;
    case (st_q)
      ST_IDLE, ST_READ, ST_WRITE: begin
        if (load) begin
          if (!sel) begin
            st_d = ST_IDLE;
          end else if (WR_SELECT_N) begin
            st_d = ST_READ;
          end else begin
            st_d = ST_WRITE;
          end
        end
        // Advance keeps the latched direction and ignores selects
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      st_q    <= ST_IDLE;
      base_q  <= {`FBSC_ADDR_W{1'b0}};
      beat_q  <= 2'h0;
      order_q <= 1'b0;
      drive_q <= 1'b0;
      rd_data_addr_q <= {`FBSC_ADDR_W{1'b0}};
    end else if (qual) begin
      st_q <= st_d;
      if (load) begin
        base_q  <= ADDR_IN;
        beat_q  <= 2'h0;
        order_q <= BURST_ORDER;
        rd_data_addr_q <= ADDR_IN;
        drive_q <= sel && WR_SELECT_N;
      end else if (burst_ok) begin
        beat_q  <= beat_n;
        rd_data_addr_q <= nxt_addr;
        drive_q <= (st_q == ST_READ);
      end else begin
        drive_q <= 1'b0;
      end
    end
  end

  // Write beats queue here; lanes are the ones presented together with the data
  fbsc_fifo #(
    .WIDTH (`FBSC_WORD_W + `FBSC_ADDR_W + 4),
    .DEPTH (`FBSC_FIFO_D),
    .AW    (`FBSC_FIFO_AW)
  ) u_fifo (
    .clk       (CLK_SYS),
    .rst_n     (RESETN),
    .in_valid  (wr_issue),
    .in_ready  (fifo_in_ready),
    .in_data   ({~LANE_WRITE_SEL_N, cur_addr, PARITY_LINES_I, DATA_LINES_I}),
    .out_valid (fifo_out_valid),
    .out_ready (1'b1),
    .out_data  (fifo_out_data)
  );

  // Pack parity beside each byte so each lane is nine contiguous bits
  genvar i;
  generate
    for (i = 0; i < `FBSC_LANES; i = i + 1) begin : pack
      assign fifo_out_word[9*i +: 9] = {fifo_out_data[32+i], fifo_out_data[8*i +: 8]};
      assign DATA_LINES_O[8*i +: 8] = core_rd[9*i +: 8];
      assign PARITY_LINES_O[i]      = core_rd[9*i+8];
    end
  endgenerate

  fbsc_core u_core (
    .clk     (CLK_SYS),
    .wr_en   (fifo_out_valid),
    .wr_addr (fifo_out_data[`FBSC_ADDR_W+35:36]),
    .wr_lane (fifo_out_data[`FBSC_ADDR_W+39:`FBSC_ADDR_W+36]),
    .wr_word (fifo_out_word),
    .rd_addr (rd_data_addr_q),
    .rd_word (core_rd)
  );

  // Output drive needs an active read beat and the master's enable
  assign DATA_LINES_OE   = {32{drive_q && !OUT_DRIVE_N}};
  assign PARITY_LINES_OE = {4{drive_q && !OUT_DRIVE_N}};
endmodule

// *** verif/fbsc_chk.sv ***
// Port assertions for the burst SRAM control block
`timescale 1ns/1ps
module fbsc_chk (
  input wire logic        CLK_SYS,
  input wire logic        RESETN,
  input wire logic        CLK_QUALIFY_N,
  input wire logic        SEL_N_A,
  input wire logic        SEL_B,
  input wire logic        SEL_N_C,
  input wire logic        ADVANCE_OR_LOAD,
  input wire logic        WR_SELECT_N,
  input wire logic        OUT_DRIVE_N,
  input wire logic [31:0] DATA_LINES_OE,
  input wire logic [3:0]  PARITY_LINES_OE
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);
  wire ld  = !CLK_QUALIFY_N && !ADVANCE_OR_LOAD;
  wire adv = !CLK_QUALIFY_N && ADVANCE_OR_LOAD;
  wire sel = !SEL_N_A && SEL_B && !SEL_N_C;
  wire off = DATA_LINES_OE == 32'h0 && PARITY_LINES_OE == 4'h0;
  wire on  = &DATA_LINES_OE && &PARITY_LINES_OE;
  sequence s_rd; ld && sel && WR_SELECT_N; endsequence
  sequence s_wr; ld && sel && !WR_SELECT_N; endsequence
  property p_read; s_rd ##1 !OUT_DRIVE_N |-> on; endproperty
  a_read: assert property (p_read) else $error("read left lines off");
  property p_wr; s_wr |=> off; endproperty
  a_wr: assert property (p_wr) else $error("lines driven in write");
  property p_desel; ld && !sel |=> off; endproperty
  a_desel: assert property (p_desel) else $error("lines driven when off");
  property p_oen; OUT_DRIVE_N |-> off; endproperty
  a_oen: assert property (p_oen) else $error("lines driven, enable high");
  property p_frz; CLK_QUALIFY_N && !OUT_DRIVE_N ##1 !OUT_DRIVE_N |-> $stable(DATA_LINES_OE); endproperty
  a_frz: assert property (p_frz) else $error("state moved on frozen edge");
  property p_rburst; s_rd ##1 adv ##1 !OUT_DRIVE_N |-> on; endproperty
  a_rburst: assert property (p_rburst) else $error("read burst lost");
  property p_wburst; s_wr ##1 adv |=> off; endproperty
  a_wburst: assert property (p_wburst) else $error("write burst drove");
  property p_idle; ld && !sel ##1 adv |=> off; endproperty
  a_idle: assert property (p_idle) else $error("advance while idle drove");
  property p_grp; DATA_LINES_OE == {32{PARITY_LINES_OE[0]}} && PARITY_LINES_OE == {4{PARITY_LINES_OE[0]}}; endproperty
  a_grp: assert property (p_grp) else $error("lanes enabled unevenly");
endmodule
bind fbsc_top fbsc_chk u_chk (.CLK_SYS(CLK_SYS), .RESETN(RESETN), .CLK_QUALIFY_N(CLK_QUALIFY_N),
  .SEL_N_A(SEL_N_A), .SEL_B(SEL_B), .SEL_N_C(SEL_N_C), .ADVANCE_OR_LOAD(ADVANCE_OR_LOAD),
  .WR_SELECT_N(WR_SELECT_N), .OUT_DRIVE_N(OUT_DRIVE_N), .DATA_LINES_OE(DATA_LINES_OE),
  .PARITY_LINES_OE(PARITY_LINES_OE));

// *** verif/fbsc_mstr.sv ***
// Bus master model: drives write data and resolves the shared lines
`timescale 1ns/1ps
module fbsc_mstr (
  input  wire logic        clk,
  input  wire logic        drv_en,
  input  wire logic [35:0] drv_word,
  input  wire logic [35:0] dev_oe,
  input  wire logic [35:0] dev_word,
  output logic      [35:0] bus
);
  logic [35:0] last_q = 36'h0;
  always_comb begin
    for (int i = 0; i < 36; i++) begin
      // Released bits toggle so a stale value never reads as valid
      bus[i] = dev_oe[i] ? dev_word[i] : drv_en ? drv_word[i] : ~last_q[i];
    end
  end
  always @(posedge clk) last_q <= bus;
endmodule

// *** verif/testbench.sv ***
// Self-checking bench for the burst SRAM control block
`timescale 1ns/1ps
module testbench;
  localparam logic [2:0] ON = 3'b010;
  logic        clk_sys = 1'b0;
  logic        resetn  = 1'b0;
  logic        qn      = 1'b0;
  logic        adv     = 1'b0;
  logic        wn      = 1'b1;
  logic        odn     = 1'b0;
  logic        mode    = 1'b0;
  logic        den     = 1'b0;
  logic [2:0]  sel     = 3'b110;
  logic [3:0]  lanes   = 4'hf;
  logic [16:0] addr    = 17'h0;
  logic [35:0] dword   = 36'h0;
  wire  [35:0] bus;
  wire  [35:0] oe;
  wire  [35:0] dout;
  wire         stall;
  int          mismatches  = 0;
  int          comparisons = 0;
  initial forever #12.5 clk_sys = ~clk_sys;
  fbsc_top dut (.CLK_SYS(clk_sys), .RESETN(resetn), .CLK_QUALIFY_N(qn), .SEL_N_A(sel[2]), .SEL_B(sel[1]),
    .SEL_N_C(sel[0]), .ADVANCE_OR_LOAD(adv), .WR_SELECT_N(wn), .LANE_WRITE_SEL_N(lanes), .ADDR_IN(addr),
    .OUT_DRIVE_N(odn), .BURST_ORDER(mode), .DATA_LINES_I(bus[31:0]), .DATA_LINES_O(dout[31:0]),
    .DATA_LINES_OE(oe[31:0]), .PARITY_LINES_I(bus[35:32]), .PARITY_LINES_O(dout[35:32]),
    .PARITY_LINES_OE(oe[35:32]), .WR_STALL(stall));
  fbsc_mstr u_mstr (.clk(clk_sys), .drv_en(den), .drv_word(dword), .dev_oe(oe), .dev_word(dout), .bus(bus));
  function automatic logic [35:0] dat(input int k);
    return 36'h3_c3c3_0000 + 36'(k);
  endfunction
  task automatic cyc(input logic l, w, input logic [2:0] s, input logic [16:0] a, input logic e,
                     input logic [35:0] d, input logic [3:0] b);
    adv = l;
    wn = w;
    sel = s;
    addr = a;
    den = e;
    dword = d;
    lanes = b;
    @(posedge clk_sys);
    #2;
  endtask
  task automatic chk(input logic [35:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic t_byte;
    cyc(0, 0, ON, 17'h1_2345, 0, 36'h0, 4'hf);
    cyc(0, 0, ON, 17'h1_2345, 1, 36'h5_1234_5678, 4'h0);
    cyc(0, 1, 3'b110, 17'h0, 1, 36'ha_cdef_9abc, 4'h5);
    repeat (3) cyc(0, 1, 3'b110, 17'h0, 0, 36'h0, 4'hf);
    cyc(0, 1, ON, 17'h1_2345, 0, 36'h0, 4'hf);
    chk(bus, 36'hf_cd34_9a78);
    $display("byte lane test done");
  endtask
  task automatic t_burst;
    mode = 1'b0;
    cyc(0, 0, ON, 17'h0_0102, 0, 36'h0, 4'hf);
    for (int k = 1; k < 4; k++) cyc(1, 1, 3'b000, 17'h0, 1, dat(k - 1), 4'h0);
    cyc(0, 1, 3'b011, 17'h0, 1, dat(3), 4'h0);
    repeat (3) cyc(0, 1, 3'b011, 17'h0, 0, 36'h0, 4'hf);
    chk({35'h0, stall}, 36'h0);
    mode = 1'b1;
    cyc(0, 1, ON, 17'h0_0101, 0, 36'h0, 4'hf);
    for (int j = 0; j < 5; j++) begin
      chk(bus, dat((3 - j) & 3));
      cyc(1, 0, 3'b110, 17'h0, 0, 36'h0, 4'h0);
    end
    $display("burst test done");
  endtask
  task automatic t_freeze;
    mode = 1'b0;
    cyc(0, 1, ON, 17'h0_0103, 0, 36'h0, 4'hf);
    chk(bus, dat(1));
    qn = 1'b1;
    repeat (2) begin
      cyc(0, 0, 3'b110, 17'h0, 0, 36'h0, 4'h0);
      chk(bus, dat(1));
    end
    qn = 1'b0;
    cyc(1, 1, ON, 17'h0, 0, 36'h0, 4'hf);
    chk(bus, dat(2));
    $display("suspend test done");
  endtask
  task automatic t_desel;
    logic [2:0] pat [3] = '{3'b110, 3'b000, 3'b011};
    foreach (pat[i]) begin
      cyc(0, 1, ON, 17'h0_0101, 0, 36'h0, 4'hf);
      chk(oe, {36{1'b1}});
      cyc(0, 1, pat[i], 17'h0_0101, 0, 36'h0, 4'hf);
      chk(oe, 36'h0);
      cyc(1, 1, ON, 17'h0, 0, 36'h0, 4'hf);
      chk(oe, 36'h0);
    end
    cyc(0, 1, ON, 17'h0_0101, 0, 36'h0, 4'hf);
    odn = 1'b1;
    cyc(1, 1, ON, 17'h0, 0, 36'h0, 4'hf);
    chk(oe, 36'h0);
    odn = 1'b0;
    cyc(1, 1, ON, 17'h0, 0, 36'h0, 4'hf);
    chk(oe, {36{1'b1}});
    $display("deselect test done");
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    #2;
    chk(oe, 36'h0);
    resetn = 1'b1;
    cyc(0, 1, 3'b110, 17'h0, 0, 36'h0, 4'hf);
    chk(oe, 36'h0);
    t_byte;
    t_burst;
    t_freeze;
    t_desel;
    summarize;
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    mismatches++;
    $display("mismatch at %0t: run did not finish", $time);
    summarize;
  end
endmodule
